//--- logic/bis_pkg.sv
package bis_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS  = 25;
  localparam int TICK_PERIOD_NS = 1000000;
  // The sequencer tick is 1 ms; delays and filter times count in ticks.
  localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Register byte addresses
  // ==========================================================================
  localparam logic [7:0] ADDR_STOP_DLY  = 8'h00;
  localparam logic [7:0] ADDR_RUN_DLY   = 8'h04;
  localparam logic [7:0] ADDR_SPD_THR   = 8'h08;
  localparam logic [7:0] ADDR_STOP_SEL  = 8'h0c;
  localparam logic [7:0] ADDR_ARST_SEL  = 8'h10;
  localparam logic [7:0] ADDR_GPO_CFG   = 8'h14;
  localparam logic [7:0] ADDR_STATUS    = 8'h18;
  localparam logic [7:0] ADDR_INT_STAT  = 8'h1c;
  localparam logic [7:0] ADDR_INT_MASK  = 8'h20;

  localparam logic [3:0] IDX_STOP_DLY  = 4'h0;
  localparam logic [3:0] IDX_RUN_DLY   = 4'h1;
  localparam logic [3:0] IDX_SPD_THR   = 4'h2;
  localparam logic [3:0] IDX_STOP_SEL  = 4'h3;
  localparam logic [3:0] IDX_ARST_SEL  = 4'h4;
  localparam logic [3:0] IDX_GPO_CFG   = 4'h5;
  localparam logic [3:0] IDX_STATUS    = 4'h6;
  localparam logic [3:0] IDX_INT_STAT  = 4'h7;
  localparam logic [3:0] IDX_INT_MASK  = 4'h8;
  localparam logic [3:0] IDX_NONE      = 4'hf;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [15:0] RST_STOP_DLY = 16'h0064;
  localparam logic [15:0] RST_RUN_DLY  = 16'h0064;
  localparam logic [15:0] RST_SPD_THR  = 16'h001e;
  localparam logic [1:0]  RST_STOP_SEL = 2'h0;
  localparam logic [7:0]  RST_ARST_SEL = 8'h78;
  localparam logic [2:0]  RST_GPO_SEL  = 3'h0;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int GPO_EN_BIT   = 3;
  localparam int NUM_GPO      = 8;
  localparam int NUM_EVT      = 5;
  localparam int EVT_ON       = 0;
  localparam int EVT_OFF_DONE = 1;
  localparam int EVT_ALARM    = 2;
  localparam int EVT_ARST     = 3;
  localparam int EVT_REFUSED  = 4;
  localparam int ST_SPEED_LOW = 6;
  localparam int ST_NEED_NEW  = 7;
  localparam int ST_ALARM_LAT = 8;
  localparam int ST_BRAKE_REL = 9;
  localparam int ST_POWER     = 10;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_ON,
    ST_STOP_DLY,
    ST_RUN_DLY,
    ST_ALARM
  } bis_state_t;

endpackage : bis_pkg

//--- logic/bis_reset_filter.sv
`timescale 1ns/1ps

module bis_reset_filter
  import bis_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       level,
  input  wire logic       tick,
  input  wire logic [7:0] limit,
  output logic            pulse
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       done;
    logic       pulse;
  } bis_filt_t;

  bis_filt_t cur;
  bis_filt_t next_cur;

  // ==========================================================================
  // Recognition filter
  // ==========================================================================
  // A level must stay high for limit ticks; one pulse per assertion, so a
  // held reset button cannot clear a fresh alarm.
  always_comb
  begin
    next_cur       = cur;
    next_cur.pulse = 1'b0;
    if (!level)
    begin
      next_cur.cnt  = 8'h00;
      next_cur.done = 1'b0;
    end
    else if (tick && !cur.done)
    begin
      if ((cur.cnt + 8'h01) >= limit)
      begin
        next_cur.pulse = 1'b1;
        next_cur.done  = 1'b1;
      end
      else
      begin
        next_cur.cnt = cur.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign pulse = cur.pulse;

endmodule : bis_reset_filter

//--- logic/bis_brake_sequencer.sv
`timescale 1ns/1ps

// Function
// - Drive brake release output at servo on, alarm and servo off.
// - Servo off while stopped: wait stopped delay, then drop brake and power.
// - Servo off while rotating: run running delay, then drop brake and power.
// - In running delay, drop early once speed is at or below threshold.
// - Speed threshold is a software setting, default 30 r/min.
// - Refuse servo on while speed is above the threshold.
// - Servo on reasserted while decelerating waits until speed is at or below the threshold.
// - Brake release output asserts only on a servo control release request.
// - Brake release reaches only the general purpose output it is assigned to.
// - Dynamic braking at servo off follows the stop selection setting.
// - Dynamic braking at alarm follows the same stop selection setting.
// - Alarm while on uses running delay or speed threshold, whichever first.
// - Main power loss raises an alarm and follows alarm release timing.
// - Alarm reset input filtered by selectable time, default 120 ms.
// - After alarm reset stay off until a fresh servo on command.
module bis_brake_sequencer
  import bis_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        servo_on_in,
  input  wire logic        alarm_in,
  input  wire logic        phase_loss_in,
  input  wire logic        main_low_in,
  input  wire logic        alarm_reset_in,
  input  wire logic [15:0] motor_speed,
  input  wire logic        brake_release_req,
  output logic             motor_power_en,
  output logic             brake_release_out,
  output logic [7:0]       gpo_out,
  output logic             dyn_brake_on,
  output logic             alarm_active,
  output logic             irq
);

  typedef struct packed {
    logic [4:0]         s1;
    logic [4:0]         s2;
    logic [15:0]        tick_cnt;
    bis_state_t         state;
    logic [15:0]        timer;
    logic               speed_low;
    logic               need_new;
    logic               alarm_lat;
    logic [15:0]        stop_dly;
    logic [15:0]        run_dly;
    logic [15:0]        spd_thr;
    logic [1:0]         stop_sel;
    logic [7:0]         arst_sel;
    logic [2:0]         gpo_sel;
    logic               gpo_en;
    logic [NUM_EVT-1:0] int_stat;
    logic [NUM_EVT-1:0] int_mask;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               motor_power_en;
    logic               brake_release_out;
    logic [7:0]         gpo_out;
    logic               dyn_brake_on;
    logic               alarm_active;
    logic               irq;
  } bis_top_t;

  localparam logic [15:0] TICK_LAST = 16'(TICK_LEN - 1);

  bis_top_t cur;
  bis_top_t next_cur;
  logic     arst_pulse;
  logic [NUM_GPO-1:0] gpo_hit;

  // ==========================================================================
  // Register decode
  // ==========================================================================
  function automatic logic [3:0] reg_index(input logic [7:0] a);
    case (a)
      ADDR_STOP_DLY: reg_index = IDX_STOP_DLY;
      ADDR_RUN_DLY:  reg_index = IDX_RUN_DLY;
      ADDR_SPD_THR:  reg_index = IDX_SPD_THR;
      ADDR_STOP_SEL: reg_index = IDX_STOP_SEL;
      ADDR_ARST_SEL: reg_index = IDX_ARST_SEL;
      ADDR_GPO_CFG:  reg_index = IDX_GPO_CFG;
      ADDR_STATUS:   reg_index = IDX_STATUS;
      ADDR_INT_STAT: reg_index = IDX_INT_STAT;
      ADDR_INT_MASK: reg_index = IDX_INT_MASK;
      default:       reg_index = IDX_NONE;
    endcase
  endfunction : reg_index

  // ==========================================================================
  // Alarm reset recognition
  // ==========================================================================
  bis_reset_filter u_reset_filter (
    .sys_clk (sys_clk),
    .reset   (reset),
    .level   (cur.s2[0]),
    .tick    (cur.tick_cnt == TICK_LAST),
    .limit   (cur.arst_sel),
    .pulse   (arst_pulse)
  );

  // ==========================================================================
  // Output routing
  // ==========================================================================
  // Only the assigned output may carry the brake line; all others stay low.
  for (genvar g = 0; g < NUM_GPO; g++)
  begin : g_gpo
    assign gpo_hit[g] = cur.gpo_en && (cur.gpo_sel == 3'(g));
  end

  // ==========================================================================
  // Sequencer, register file and outputs
  // ==========================================================================
  always_comb
  begin
    logic               tick;
    logic               svon;
    logic               alarm_any;
    logic               powered;
    logic               rel;
    logic               expire;
    logic [NUM_EVT-1:0] ev;
    logic [3:0]         idx;
    logic               wr;
    logic [31:0]        status;
    tick      = 1'b0;
    svon      = 1'b0;
    alarm_any = 1'b0;
    powered   = 1'b0;
    rel       = 1'b0;
    expire    = 1'b0;
    ev        = '0;
    idx       = IDX_NONE;
    wr        = 1'b0;
    status    = 32'h00000000;
    next_cur  = cur;

    // Pins pass two flops; only the second stage is used below.
    next_cur.s1 = {servo_on_in, alarm_in, phase_loss_in, main_low_in, alarm_reset_in};
    next_cur.s2 = cur.s1;
    svon        = cur.s2[4];
    alarm_any   = |cur.s2[3:1];

    tick = (cur.tick_cnt == TICK_LAST);
    next_cur.tick_cnt = tick ? 16'h0000 : cur.tick_cnt + 16'h0001;
    if (tick)
    begin
      // Speed is judged once per tick so a noisy estimate cannot chatter.
      next_cur.speed_low = (motor_speed <= cur.spd_thr);
      if (cur.timer != 16'hffff)
        next_cur.timer = cur.timer + 16'h0001;
    end

    case (cur.state)
      ST_OFF:
      begin
        if (alarm_any)
        begin
          next_cur.state     = ST_ALARM;
          next_cur.alarm_lat = 1'b1;
          ev[EVT_ALARM]      = 1'b1;
        end
        // A command held through an alarm reset must drop before it counts.
        else if (!svon)
          next_cur.need_new = 1'b0;
        else if (!cur.need_new)
        begin
          if (cur.speed_low)
          begin
            next_cur.state = ST_ON;
            ev[EVT_ON]     = 1'b1;
          end
          else
            ev[EVT_REFUSED] = 1'b1;
        end
      end
      ST_ON:
      begin
        // Holding the timer at zero makes each delay start from a fresh count.
        next_cur.timer = 16'h0000;
        if (alarm_any)
        begin
          next_cur.state     = ST_RUN_DLY;
          next_cur.alarm_lat = 1'b1;
          ev[EVT_ALARM]      = 1'b1;
        end
        else if (!svon)
          next_cur.state = cur.speed_low ? ST_STOP_DLY : ST_RUN_DLY;
      end
      ST_STOP_DLY:
      begin
        if (alarm_any && !cur.alarm_lat)
        begin
          next_cur.alarm_lat = 1'b1;
          ev[EVT_ALARM]      = 1'b1;
        end
        expire = tick && (cur.timer >= cur.stop_dly);
      end
      ST_RUN_DLY:
      begin
        if (alarm_any && !cur.alarm_lat)
        begin
          next_cur.alarm_lat = 1'b1;
          ev[EVT_ALARM]      = 1'b1;
        end
        // Whichever comes first: the set delay or the slow-speed judgement.
        expire = tick && ((cur.timer >= cur.run_dly) || cur.speed_low);
      end
      ST_ALARM:
      begin
        if (arst_pulse && !alarm_any)
        begin
          next_cur.state     = ST_OFF;
          next_cur.alarm_lat = 1'b0;
          next_cur.need_new  = 1'b1;
          ev[EVT_ARST]       = 1'b1;
        end
      end
      default:
      begin
        next_cur.state = ST_OFF;
      end
    endcase

    // An alarm seen during either delay still ends in the alarm state.
    if (expire)
    begin
      next_cur.state    = next_cur.alarm_lat ? ST_ALARM : ST_OFF;
      ev[EVT_OFF_DONE]  = 1'b1;
    end

    powered = (next_cur.state == ST_ON) || (next_cur.state == ST_STOP_DLY) ||
              (next_cur.state == ST_RUN_DLY);
    rel     = powered && brake_release_req;
    next_cur.motor_power_en    = powered;
    next_cur.brake_release_out = rel;
    next_cur.gpo_out = rel ? gpo_hit : 8'h00;
    // Bit 1 clear brakes while still turning, bit 0 clear brakes once stopped.
    next_cur.dyn_brake_on = !powered &&
                            (next_cur.speed_low ? !cur.stop_sel[0] : !cur.stop_sel[1]);
    next_cur.alarm_active = next_cur.alarm_lat;

    // Status bits sit at fixed positions so software can test them directly.
    status[2:0]          = cur.state;
    status[ST_SPEED_LOW] = cur.speed_low;
    status[ST_NEED_NEW]  = cur.need_new;
    status[ST_ALARM_LAT] = cur.alarm_lat;
    status[ST_BRAKE_REL] = cur.brake_release_out;
    status[ST_POWER]     = cur.motor_power_en;

    // APB: the answer is prepared in the setup cycle and given in the first
    // access cycle, so the slave never inserts a wait state.
    idx              = reg_index(paddr);
    next_cur.pready  = psel && !penable;
    next_cur.pslverr = psel && !penable && (idx == IDX_NONE);
    if (psel && !penable)
    begin
      case (idx)
        IDX_STOP_DLY: next_cur.prdata = {16'h0000, cur.stop_dly};
        IDX_RUN_DLY:  next_cur.prdata = {16'h0000, cur.run_dly};
        IDX_SPD_THR:  next_cur.prdata = {16'h0000, cur.spd_thr};
        IDX_STOP_SEL: next_cur.prdata = {30'h0, cur.stop_sel};
        IDX_ARST_SEL: next_cur.prdata = {24'h000000, cur.arst_sel};
        IDX_GPO_CFG:  next_cur.prdata = {28'h0000000, cur.gpo_en, cur.gpo_sel};
        IDX_STATUS:   next_cur.prdata = status;
        IDX_INT_STAT: next_cur.prdata = {27'h0, cur.int_stat};
        IDX_INT_MASK: next_cur.prdata = {27'h0, cur.int_mask};
        default:      next_cur.prdata = 32'h00000000;
      endcase
    end

    // Writes land only on the access edge that also shows ready.
    wr = psel && penable && cur.pready && pwrite;
    next_cur.int_stat = cur.int_stat;
    if (wr)
    begin
      case (idx)
        IDX_STOP_DLY: next_cur.stop_dly = pwdata[15:0];
        IDX_RUN_DLY:  next_cur.run_dly  = pwdata[15:0];
        IDX_SPD_THR:  next_cur.spd_thr  = pwdata[15:0];
        IDX_STOP_SEL: next_cur.stop_sel = pwdata[1:0];
        IDX_ARST_SEL: next_cur.arst_sel = pwdata[7:0];
        IDX_GPO_CFG:
        begin
          next_cur.gpo_sel = pwdata[2:0];
          next_cur.gpo_en  = pwdata[GPO_EN_BIT];
        end
        IDX_INT_STAT: next_cur.int_stat = cur.int_stat & ~pwdata[NUM_EVT-1:0];
        IDX_INT_MASK: next_cur.int_mask = pwdata[NUM_EVT-1:0];
        default:      next_cur.int_stat = cur.int_stat;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    next_cur.int_stat = next_cur.int_stat | ev;
    next_cur.irq      = |(next_cur.int_stat & next_cur.int_mask);
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      cur          <= '0;
      cur.state    <= ST_OFF;
      cur.stop_dly <= RST_STOP_DLY;
      cur.run_dly  <= RST_RUN_DLY;
      cur.spd_thr  <= RST_SPD_THR;
      cur.stop_sel <= RST_STOP_SEL;
      cur.arst_sel <= RST_ARST_SEL;
      cur.gpo_sel  <= RST_GPO_SEL;
      // Speed is unknown until the first tick; treat it as moving.
      cur.speed_low <= 1'b0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign prdata            = cur.prdata;
  assign pready            = cur.pready;
  assign pslverr           = cur.pslverr;
  assign motor_power_en    = cur.motor_power_en;
  assign brake_release_out = cur.brake_release_out;
  assign gpo_out           = cur.gpo_out;
  assign dyn_brake_on      = cur.dyn_brake_on;
  assign alarm_active      = cur.alarm_active;
  assign irq               = cur.irq;

endmodule : bis_brake_sequencer

//--- tb/bis_brake_monitor.sv
`timescale 1ns/1ps

module bis_brake_monitor (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       servo_on_in,
  input wire logic       alarm_in,
  input wire logic       phase_loss_in,
  input wire logic       main_low_in,
  input wire logic       brake_release_req,
  input wire logic       motor_power_en,
  input wire logic       brake_release_out,
  input wire logic [7:0] gpo_out,
  input wire logic       dyn_brake_on,
  input wire logic       alarm_active
);
  // ==========================================================================
  // Sequences
  // ==========================================================================
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  sequence apb_setup;
    psel && !penable;
  endsequence

  sequence alarm_rise;
    $rose(alarm_in || phase_loss_in || main_low_in);
  endsequence

  // ==========================================================================
  // Assertions
  // ==========================================================================
  // The bounds of 400 cycles assume the bench's short tick and delays.
  chk_apb_answer: assert property (apb_setup |=> pready)
    else $error("no ready after setup");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_brake_req: assert property (
    brake_release_out |-> motor_power_en && $past(brake_release_req))
    else $error("brake released without request");
  chk_drop_together: assert property (
    $fell(motor_power_en) |-> !brake_release_out)
    else $error("brake still released at power off");
  chk_gpo_single: assert property ($onehot0(gpo_out))
    else $error("brake on more than one output");
  chk_gpo_follows: assert property (
    (|gpo_out) |-> brake_release_out || $past(brake_release_out))
    else $error("output set without brake release");
  chk_dyn_unpowered: assert property (
    motor_power_en |-> !dyn_brake_on)
    else $error("dynamic brake while powered");
  chk_power_cmd: assert property (
    $rose(motor_power_en) |-> $past(servo_on_in, 3))
    else $error("power on without command");
  chk_alarm_latch: assert property (alarm_rise |-> ##[1:400] alarm_active)
    else $error("alarm not latched");
  chk_alarm_power: assert property (
    alarm_rise ##0 motor_power_en |-> ##[1:400] !motor_power_en)
    else $error("power kept after alarm");
endmodule : bis_brake_monitor

bind bis_brake_sequencer bis_brake_monitor u_mon (
  .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .servo_on_in(servo_on_in), .alarm_in(alarm_in),
  .phase_loss_in(phase_loss_in), .main_low_in(main_low_in),
  .brake_release_req(brake_release_req), .motor_power_en(motor_power_en),
  .brake_release_out(brake_release_out), .gpo_out(gpo_out),
  .dyn_brake_on(dyn_brake_on), .alarm_active(alarm_active));

//--- tb/bis_motor_model.sv
`timescale 1ns/1ps

module bis_motor_model
  import bis_pkg::*;
#(
  parameter int DECAY = 2
)
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        motor_power_en,
  input  wire logic        brake_line,
  input  wire logic [15:0] target_speed,
  output logic      [15:0] motor_speed
);
  // ==========================================================================
  // Shaft speed
  // ==========================================================================
  logic [15:0] goal;
  logic [15:0] step;

  // An engaged brake drags the shaft down four times faster, which is the
  // wear a short delay causes.
  always_comb
  begin
    goal = (motor_power_en && brake_line) ? target_speed : 16'h0;
    step = brake_line ? 16'(DECAY) : 16'(4 * DECAY);
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      motor_speed <= 16'h0;
    else if (motor_speed < goal)
      motor_speed <= motor_speed + 16'(DECAY);
    else if (motor_speed > goal + step)
      motor_speed <= motor_speed - step;
    else
      motor_speed <= goal;
  end
endmodule : bis_motor_model

//--- tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import bis_pkg::*;
  logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr, irq;
  logic        servo_on_in, alarm_in, phase_loss_in, main_low_in, alarm_reset_in;
  logic        brake_release_req, motor_power_en, brake_release_out, dyn_brake_on;
  logic        alarm_active, er;
  logic [7:0]  paddr, gpo_out;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] motor_speed, target_speed;
  int          n, failures, tests_run;

  bis_brake_sequencer #(.TICK_LEN(20)) uut (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .servo_on_in(servo_on_in), .alarm_in(alarm_in), .phase_loss_in(phase_loss_in),
    .main_low_in(main_low_in), .alarm_reset_in(alarm_reset_in), .motor_speed(motor_speed),
    .brake_release_req(brake_release_req), .motor_power_en(motor_power_en),
    .brake_release_out(brake_release_out), .gpo_out(gpo_out), .dyn_brake_on(dyn_brake_on),
    .alarm_active(alarm_active), .irq(irq));

  bis_motor_model u_motor (
    .sys_clk(sys_clk), .reset(reset), .motor_power_en(motor_power_en),
    .brake_line(gpo_out[2]), .target_speed(target_speed), .motor_speed(motor_speed));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // The leading edge keeps two transfers from touching psel in one step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'h1 && k < 16);
    if (k >= 16)
    begin
      failures++;
      test_done;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wait_for(input int sel, input logic v, input int lim);
    n = 0;
    while ((sel == 0 ? motor_power_en : alarm_active) !== v)
    begin
      @(posedge sys_clk);
      n++;
      if (n > lim)
      begin
        failures++;
        test_done;
      end
    end
  endtask : wait_for

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic s_registers;
    apb(1'h0, ADDR_STOP_DLY, 32'h0);
    check(rd, {16'h0, RST_STOP_DLY});
    apb(1'h0, ADDR_RUN_DLY, 32'h0);
    check(rd, {16'h0, RST_RUN_DLY});
    apb(1'h0, ADDR_SPD_THR, 32'h0);
    check(rd, {16'h0, RST_SPD_THR});
    apb(1'h0, ADDR_ARST_SEL, 32'h0);
    check(rd, {24'h0, RST_ARST_SEL});
    apb(1'h0, 8'h24, 32'h0);
    check({rd[30:0], er}, 32'h1);
    apb(1'h1, ADDR_STOP_DLY, 32'h4);
    apb(1'h1, ADDR_RUN_DLY, 32'ha);
    apb(1'h1, ADDR_GPO_CFG, 32'ha);
    apb(1'h0, ADDR_GPO_CFG, 32'h0);
    check(rd, 32'ha);
  endtask : s_registers

  task automatic s_stopped;
    servo_on_in <= 1'h1;
    wait_for(0, 1'h1, 200);
    @(posedge sys_clk);
    check({brake_release_out, gpo_out, irq}, 10'h208);
    brake_release_req <= 1'h0;
    repeat (3) @(posedge sys_clk);
    check({motor_power_en, brake_release_out, gpo_out}, 10'h200);
    brake_release_req <= 1'h1;
    @(posedge sys_clk);
    servo_on_in <= 1'h0;
    wait_for(0, 1'h0, 200);
    check(n >= 60 && n <= 130, 1'h1);
    repeat (3) @(posedge sys_clk);
    check({brake_release_out, dyn_brake_on}, 2'h1);
  endtask : s_stopped

  task automatic s_running;
    target_speed <= 16'h03e8;
    servo_on_in <= 1'h1;
    wait_for(0, 1'h1, 200);
    repeat (600) @(posedge sys_clk);
    servo_on_in <= 1'h0;
    wait_for(0, 1'h0, 300);
    check(n >= 180 && n <= 250, 1'h1);
    servo_on_in <= 1'h1;
    repeat (60) @(posedge sys_clk);
    check(motor_power_en, 1'h0);
    wait_for(0, 1'h1, 800);
    check(motor_speed <= 16'h1e, 1'h1);
  endtask : s_running

  task automatic s_early;
    apb(1'h1, ADDR_RUN_DLY, 32'hc8);
    repeat (600) @(posedge sys_clk);
    target_speed <= 16'h0;
    servo_on_in <= 1'h0;
    wait_for(0, 1'h0, 900);
    check(n >= 400 && n <= 700, 1'h1);
    apb(1'h1, ADDR_RUN_DLY, 32'ha);
  endtask : s_early

  task automatic s_alarm;
    apb(1'h1, ADDR_STOP_SEL, 32'h2);
    apb(1'h1, ADDR_INT_MASK, 32'h4);
    target_speed <= 16'h03e8;
    servo_on_in <= 1'h1;
    wait_for(0, 1'h1, 300);
    repeat (600) @(posedge sys_clk);
    phase_loss_in <= 1'h1;
    wait_for(0, 1'h0, 400);
    repeat (2) @(posedge sys_clk);
    check({alarm_active, irq, dyn_brake_on}, 3'h6);
    phase_loss_in <= 1'h0;
    apb(1'h1, ADDR_INT_STAT, 32'h4);
    repeat (2) @(posedge sys_clk);
    check(irq, 1'h0);
    apb(1'h1, ADDR_ARST_SEL, 32'h3);
    alarm_reset_in <= 1'h1;
    repeat (20) @(posedge sys_clk);
    alarm_reset_in <= 1'h0;
    repeat (100) @(posedge sys_clk);
    check(alarm_active, 1'h1);
    alarm_reset_in <= 1'h1;
    wait_for(1, 1'h0, 200);
    alarm_reset_in <= 1'h0;
    repeat (100) @(posedge sys_clk);
    check(motor_power_en, 1'h0);
    servo_on_in <= 1'h0;
    repeat (10) @(posedge sys_clk);
    servo_on_in <= 1'h1;
    wait_for(0, 1'h1, 200);
    @(posedge sys_clk);
    check(brake_release_out, 1'h1);
  endtask : s_alarm

  // ==========================================================================
  // Clock and main sequence
  // ==========================================================================
  initial
  begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial
  begin
    {reset, brake_release_req} = 2'h3;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {servo_on_in, alarm_in, phase_loss_in, main_low_in, alarm_reset_in} = 5'h0;
    target_speed = 16'h0;
    failures = 0;
    tests_run = 0;
    repeat (6) @(posedge sys_clk);
    reset <= 1'h0;
    s_registers;
    s_stopped;
    s_running;
    s_early;
    s_alarm;
    test_done;
  end
endmodule : tb_top
